// File: hdl/wwd_consts.svh
// constants of the windowed watchdog: offsets, fields, values, counts
`ifndef WWD_CONSTS_SVH
`define WWD_CONSTS_SVH

`define WWD_KEY_ADDR 16'hff99
`define WWD_KEY_VALUE 8'hac
`define WWD_KEY_RST_ON 8'h9a
`define WWD_KEY_RST_OFF 8'h1a
`define WWD_OPT_ADDR 16'h0080
`define WWD_OPT_WIN_HI 6
`define WWD_OPT_WIN_LO 5
`define WWD_OPT_CNT_EN 4
`define WWD_OPT_OVF_HI 3
`define WWD_OPT_OVF_LO 1
`define WWD_OPT_LOCK 0
`define WWD_OVF_EXP_BASE 5'h0a
`define WWD_CNT_W 17
`define WWD_EXEMPT0_LO 16'hfb00
`define WWD_EXEMPT0_HI 16'hffcf
`define WWD_EXEMPT1_LO 16'hffe0
`define WWD_EXEMPT1_HI 16'hffff
`define WWD_CAUSE_BIT 4
`define WWD_OPT_SETTLE 2'h2

`endif

// File: hdl/wwd_pkg.sv
// types shared by the windowed watchdog modules
`default_nettype none
package wwd_pkg;
  typedef enum logic [2:0] {
    WWD_ST_LOAD = 3'b001,
    WWD_ST_RUN = 3'b010,
    WWD_ST_FAULT = 3'b100
  } wwd_state_t;
  typedef logic [16:0] wwd_count_t;
  typedef logic [15:0] wwd_addr_t;
  typedef logic [7:0] wwd_byte_t;
endpackage
`default_nettype wire

// File: hdl/wwd_evt_if.sv
// carrier between the watchdog core and its helper modules
`default_nettype none
interface wwd_evt_if;
  logic ce;
  logic ls_tick;
  logic det_en;
  logic acc_fault;
  modport sync_side (input ce, output ls_tick);
  modport chk_side (input ce, input det_en, output acc_fault);
  modport core (output ce, output det_en, input ls_tick, input acc_fault);
endinterface
`default_nettype wire

// File: hdl/wwd_ls_sync.sv
// low-speed oscillator synchroniser and rising-edge tick
`default_nettype none
module wwd_ls_sync (
  input wire logic clk,
  input wire logic rst,
  input wire logic ls_osc,
  wwd_evt_if.sync_side evt
);
  import wwd_pkg::*;
  logic s1_reg, s1_next;
  logic s2_reg, s2_next;
  logic s3_reg, s3_next;
  logic tick_reg, tick_next;

  always_comb begin
    s1_next = ls_osc;
    s2_next = s1_reg;
    s3_next = s2_reg;
    // edge seen only on the second and third stages
    tick_next = s2_reg & ~s3_reg;
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      s1_reg <= 1'b0;
      s2_reg <= 1'b0;
      s3_reg <= 1'b0;
      tick_reg <= 1'b0;
    end else if (evt.ce) begin
      s1_reg <= s1_next;
      s2_reg <= s2_next;
      s3_reg <= s3_next;
      tick_reg <= tick_next;
    end
  end

  assign evt.ls_tick = tick_reg;
endmodule
`default_nettype wire

// File: hdl/wwd_acc_chk.sv
// illegal fetch and data access detector
`default_nettype none
`include "wwd_consts.svh"
module wwd_acc_chk (
  input wire logic clk,
  input wire logic rst,
  input wire logic fetch,
  input wire logic data_acc,
  input wire wwd_pkg::wwd_addr_t addr,
  input wire logic area_hit,
  wwd_evt_if.chk_side evt
);
  import wwd_pkg::*;
  logic fault_reg, fault_next;

  function automatic logic in_exempt(input wwd_addr_t a);
    in_exempt = ((a >= `WWD_EXEMPT0_LO) && (a <= `WWD_EXEMPT0_HI)) ||
                ((a >= `WWD_EXEMPT1_LO) && (a <= `WWD_EXEMPT1_HI));
  endfunction

  always_comb begin
    fault_next = 1'b0;
    if (evt.det_en) begin
      if (fetch && !area_hit)
        fault_next = 1'b1; // [RQ7]
      if (data_acc && !area_hit && !in_exempt(addr))
        fault_next = 1'b1; // [RQ8]
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst)
      fault_reg <= 1'b0;
    else if (evt.ce)
      fault_reg <= fault_next;
  end

  assign evt.acc_fault = fault_reg;
endmodule
`default_nettype wire

// File: hdl/wwd_top.sv
// windowed watchdog core: counter, window, key register, fault request
`default_nettype none
`include "wwd_consts.svh"

// Operation
// [RQ1] counter advances only on low-speed oscillator ticks
// [RQ2] overflow without restart raises a reset request
// [RQ3] single-bit access to key register raises a reset request
// [RQ4] writing a non-key byte to key register raises a reset request
// [RQ5] key faults while source clock stopped wait until it runs again
// [RQ6] key write in closed window raises reset request, even correct key
// [RQ7] enabled detection: fetch outside configured areas raises reset
// [RQ8] enabled detection: data access outside areas resets, two exempt ranges
// [RQ9] watchdog reset sets cause flag, bit 4 of cause register
// [RQ10] 8-bit key write clears counter and restarts from zero
// [RQ11] key register reset value 9a enabled, 1a disabled
// [RQ12] key register reads return its reset value, never the key
// [RQ13] configuration from option byte: window, enable, overflow select
// [RQ14] enable 0 stops counter and detection; 1 starts both at release
// [RQ15] first key write after release restarts regardless of window
// [RQ16] later key writes only in open window, enforced by reset
// [RQ17] restart overflow time may differ by two low-speed periods
// [RQ18] key write restarts even in the last count before overflow
// [RQ19] lock 0: pause in halt and stop, resume from held value
// [RQ20] lock 1: keep counting through halt and stop
// [RQ21] lock 0 and oscillator stop bit set: counter stops, keeps count
// [RQ22] counting continues during flash self-programming
// [RQ23] overflow time is 2 to the power 10 plus select periods
// [RQ24] window select opens final 25, 50, 75 or 100 percent
// [RQ25] shortest overflow with 25 percent window is prohibited
// [RQ26] each fault gives one reset request pulse with cause flag
module wwd_top (
  input wire logic I_CORE_CLK,
  input wire logic I_RST,
  input wire logic I_CE,
  input wire logic I_LS_OSC,
  input wire wwd_pkg::wwd_byte_t I_OPT_BYTE,
  input wire logic I_REG_WR,
  input wire logic I_REG_RD,
  input wire logic I_REG_BITOP,
  input wire wwd_pkg::wwd_addr_t I_REG_ADDR,
  input wire wwd_pkg::wwd_byte_t I_REG_WDATA,
  output logic [7:0] O_REG_RDATA,
  input wire logic I_FETCH,
  input wire logic I_DATA_ACC,
  input wire wwd_pkg::wwd_addr_t I_ACC_ADDR,
  input wire logic I_AREA_HIT,
  input wire logic I_HALT,
  input wire logic I_STOP,
  input wire logic I_LS_OSC_STOP,
  output logic O_RST_REQ,
  output logic O_CAUSE_FLAG,
  output logic O_RUNNING
);
  import wwd_pkg::*;

  wwd_evt_if evt ();

  wwd_ls_sync u_sync (
    .clk(I_CORE_CLK),
    .rst(I_RST),
    .ls_osc(I_LS_OSC),
    .evt(evt.sync_side)
  );

  wwd_acc_chk u_chk (
    .clk(I_CORE_CLK),
    .rst(I_RST),
    .fetch(I_FETCH),
    .data_acc(I_DATA_ACC),
    .addr(I_ACC_ADDR),
    .area_hit(I_AREA_HIT),
    .evt(evt.chk_side)
  );

  // option byte strap, synchronised then caught once after release
  wwd_byte_t opt_s1_reg, opt_s1_next;
  wwd_byte_t opt_s2_reg, opt_s2_next;
  wwd_byte_t opt_reg, opt_next;
  logic [1:0] settle_reg, settle_next;

  wwd_state_t state_reg, state_next;
  wwd_count_t count_reg, count_next;
  logic first_done_reg, first_done_next;
  logic pend_reg, pend_next;
  logic req_reg, req_next;
  logic cause_reg, cause_next;
  logic run_reg, run_next;
  wwd_byte_t rdata_reg, rdata_next;

  logic cnt_en;
  logic lock;
  logic [2:0] ovf_sel;
  logic [1:0] win_sel;
  logic src_run;
  logic key_acc;
  logic key_bad;
  logic key_ok;
  logic closed;
  logic last_count;
  wwd_count_t limit_m1;
  wwd_count_t close_lim;

  // last count value before overflow for the chosen select
  function automatic wwd_count_t ovf_last(input logic [2:0] sel);
    logic [4:0] sh;
    sh = `WWD_OVF_EXP_BASE + {2'b00, sel};
    ovf_last = wwd_count_t'((18'h00001 << sh) - 18'h00001); // [RQ23]
  endfunction

  // first open count: closed part is the leading share of the period
  function automatic wwd_count_t closed_end(input logic [2:0] sel,
                                            input logic [1:0] win);
    wwd_count_t q;
    q = wwd_count_t'(ovf_last(sel) >> 2) + 17'h00001;
    case (win)
      2'b00: closed_end = wwd_count_t'(q + q + q); // [RQ24]
      2'b01: closed_end = wwd_count_t'(q + q);
      2'b10: closed_end = q;
      default: closed_end = 17'h00000;
    endcase
  endfunction

  function automatic wwd_byte_t key_rst_val(input logic en);
    key_rst_val = en ? `WWD_KEY_RST_ON : `WWD_KEY_RST_OFF; // [RQ11]
  endfunction

  always_comb begin
    cnt_en = opt_reg[`WWD_OPT_CNT_EN]; // [RQ13]
    lock = opt_reg[`WWD_OPT_LOCK];
    ovf_sel = opt_reg[`WWD_OPT_OVF_HI:`WWD_OPT_OVF_LO];
    win_sel = opt_reg[`WWD_OPT_WIN_HI:`WWD_OPT_WIN_LO];
    // prohibited 000/00 pair is not trapped; it behaves as coded [RQ25]
    limit_m1 = ovf_last(ovf_sel);
    close_lim = closed_end(ovf_sel, win_sel);
    // lock 1 ignores halt, stop and the oscillator stop bit [RQ20]
    src_run = lock | ~(I_HALT | I_STOP | I_LS_OSC_STOP); // [RQ19] [RQ21]
    key_acc = I_REG_WR && (I_REG_ADDR == `WWD_KEY_ADDR);
    closed = first_done_reg && (count_reg < close_lim); // [RQ15] [RQ16]
    key_bad = key_acc && (I_REG_BITOP || // [RQ3]
              (I_REG_WDATA != `WWD_KEY_VALUE) || closed); // [RQ4] [RQ6]
    key_ok = key_acc && !key_bad;
    last_count = (count_reg == limit_m1);
  end

  always_comb begin
    opt_s1_next = I_OPT_BYTE;
    opt_s2_next = opt_s1_reg;
    opt_next = opt_reg;
    settle_next = settle_reg;
    state_next = state_reg;
    count_next = count_reg;
    first_done_next = first_done_reg;
    pend_next = pend_reg;
    req_next = 1'b0;
    cause_next = cause_reg;
    run_next = 1'b0;
    rdata_next = 8'h00;
    case (state_reg)
      WWD_ST_LOAD: begin
        if (settle_reg == `WWD_OPT_SETTLE) begin
          opt_next = opt_s2_reg;
          state_next = WWD_ST_RUN;
        end else begin
          settle_next = settle_reg + 2'h1;
        end
      end
      WWD_ST_RUN: begin
        run_next = cnt_en & src_run; // [RQ14]
        if (I_REG_RD && I_REG_ADDR == `WWD_KEY_ADDR)
          rdata_next = key_rst_val(cnt_en); // [RQ12]
        if (cnt_en) begin
          // counting carries on whatever the flash is doing [RQ22]
          if (key_ok) begin
            // restart is async to the tick phase: up to one period slips
            count_next = 17'h00000; // [RQ10] [RQ17]
            first_done_next = 1'b1; // [RQ15]
          end else if (evt.ls_tick && src_run) begin
            count_next = wwd_count_t'(count_reg + 17'h00001); // [RQ1]
          end
          // a key fault seen while the source is stopped waits for it
          if (key_bad)
            pend_next = 1'b1; // [RQ5]
          if ((pend_reg || key_bad) && src_run)
            req_next = 1'b1; // [RQ5]
          // key write in the final count wins over the overflow
          if (!key_ok && last_count && evt.ls_tick && src_run)
            req_next = 1'b1; // [RQ2] [RQ18]
          if (evt.acc_fault)
            req_next = 1'b1; // [RQ7] [RQ8]
          if (req_next) begin
            cause_next = 1'b1; // [RQ9] [RQ26]
            state_next = WWD_ST_FAULT;
          end
        end
      end
      WWD_ST_FAULT: begin
        // single pulse; only an outside reset leaves this state
        if (I_REG_RD && I_REG_ADDR == `WWD_KEY_ADDR)
          rdata_next = key_rst_val(cnt_en);
      end
      default: begin
        state_next = WWD_ST_LOAD;
      end
    endcase
  end

  always_ff @(posedge I_CORE_CLK or posedge I_RST) begin
    if (I_RST) begin
      opt_s1_reg <= 8'h00;
      opt_s2_reg <= 8'h00;
      opt_reg <= 8'h00;
      settle_reg <= 2'h0;
      state_reg <= WWD_ST_LOAD;
      count_reg <= 17'h00000;
      first_done_reg <= 1'b0;
      pend_reg <= 1'b0;
      req_reg <= 1'b0;
      cause_reg <= 1'b0;
      run_reg <= 1'b0;
      rdata_reg <= 8'h00;
    end else if (I_CE) begin
      opt_s1_reg <= opt_s1_next;
      opt_s2_reg <= opt_s2_next;
      opt_reg <= opt_next;
      settle_reg <= settle_next;
      state_reg <= state_next;
      count_reg <= count_next;
      first_done_reg <= first_done_next;
      pend_reg <= pend_next;
      req_reg <= req_next;
      cause_reg <= cause_next;
      run_reg <= run_next;
      rdata_reg <= rdata_next;
    end
  end

  assign evt.ce = I_CE;
  assign evt.det_en = (state_reg == WWD_ST_RUN) && cnt_en; // [RQ14]

  assign O_RST_REQ = req_reg; // [RQ26]
  assign O_CAUSE_FLAG = cause_reg; // [RQ9]
  assign O_RUNNING = run_reg;
  assign O_REG_RDATA = rdata_reg;
endmodule
`default_nettype wire

// File: dv/wwd_monitor.sv
// port checker of the windowed watchdog
`default_nettype none
`include "wwd_consts.svh"
module wwd_monitor (
  input wire logic I_CORE_CLK,
  input wire logic I_RST,
  input wire logic I_CE,
  input wire logic I_REG_WR,
  input wire logic I_REG_RD,
  input wire logic I_REG_BITOP,
  input wire wwd_pkg::wwd_addr_t I_REG_ADDR,
  input wire wwd_pkg::wwd_byte_t I_REG_WDATA,
  input wire logic [7:0] O_REG_RDATA,
  input wire logic I_FETCH,
  input wire logic I_AREA_HIT,
  input wire logic O_RST_REQ,
  input wire logic O_CAUSE_FLAG,
  input wire logic O_RUNNING
);
  default clocking @(posedge I_CORE_CLK); endclocking
  default disable iff (I_RST);
  logic live;
  logic key;
  // faults are judged only while counting and not yet faulted
  assign live = I_CE && O_RUNNING && !O_CAUSE_FLAG;
  assign key = I_REG_ADDR == `WWD_KEY_ADDR;
  sequence s_bad_key;
    live && I_REG_WR && key && I_REG_WDATA != `WWD_KEY_VALUE;
  endsequence
  sequence s_bad_fetch;
    live && I_FETCH && !I_AREA_HIT;
  endsequence
  property p_bad_key;
    s_bad_key |=> O_RST_REQ && O_CAUSE_FLAG;
  endproperty
  a_bad_key: assert property (p_bad_key) else $error("bad key");
  property p_bitop;
    live && I_REG_WR && I_REG_BITOP && key |=> O_RST_REQ;
  endproperty
  a_bitop: assert property (p_bitop) else $error("bit access");
  property p_fetch;
    s_bad_fetch |-> ##2 O_RST_REQ;
  endproperty
  a_fetch: assert property (p_fetch) else $error("bad fetch");
  property p_pulse;
    O_RST_REQ |=> !O_RST_REQ [*8];
  endproperty
  a_pulse: assert property (p_pulse) else $error("second pulse");
  property p_rise;
    $rose(O_CAUSE_FLAG) |-> O_RST_REQ;
  endproperty
  a_rise: assert property (p_rise) else $error("flag alone");
  property p_hold;
    O_CAUSE_FLAG |=> O_CAUSE_FLAG;
  endproperty
  a_hold: assert property (p_hold) else $error("flag lost");
  property p_read;
    I_CE && O_RUNNING && I_REG_RD && key |=> O_REG_RDATA == `WWD_KEY_RST_ON;
  endproperty
  a_read: assert property (p_read) else $error("key read");
  property p_idle;
    I_CE && !(I_REG_RD && key) |=> O_REG_RDATA == 8'h00;
  endproperty
  a_idle: assert property (p_idle) else $error("idle read");
endmodule
bind wwd_top wwd_monitor i_mon (.I_CORE_CLK, .I_RST, .I_CE, .I_REG_WR,
  .I_REG_RD, .I_REG_BITOP, .I_REG_ADDR, .I_REG_WDATA, .O_REG_RDATA,
  .I_FETCH, .I_AREA_HIT, .O_RST_REQ, .O_CAUSE_FLAG, .O_RUNNING);
`default_nettype wire

// File: dv/wwd_host_model.sv
// core side: free low-speed oscillator and reset request tally
`default_nettype none
module wwd_host_model (
  input wire logic clk,
  input wire logic rst_req,
  output logic ls_osc,
  output int req_n
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [2:0] div = 3'h0;
  int n = 0;
  // eight core cycles a period, above the three-cycle phase minimum
  assign ls_osc = div[2];
  assign req_n = n;
  always @(posedge clk) begin
    div <= div + 3'h1;
    if (rst_req)
      n <= n + 1;
  end
endmodule
`default_nettype wire

// File: dv/windowed_watchdog_timer_bench.sv
// self-checking bench of the windowed watchdog
`default_nettype none
`include "wwd_consts.svh"
module windowed_watchdog_timer_bench;
  timeunit 1ns;
  timeprecision 1ns;
  import wwd_pkg::*;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic bop = 1'b0;
  logic fch = 1'b0;
  logic dac = 1'b0;
  logic hit = 1'b1;
  logic halt = 1'b0;
  logic stp = 1'b0;
  logic ostp = 1'b0;
  logic run;
  logic ls;
  logic req;
  logic flag;
  logic [7:0] rdata;
  wwd_addr_t addr = 16'h0000;
  wwd_addr_t aad = 16'h0000;
  wwd_byte_t wd = 8'h00;
  wwd_byte_t opt = 8'h30;
  int req_n;
  int base;
  int cyc = 0;
  int err_count = 0;
  int check_count = 0;
  always #20 clk = ~clk;
  wwd_top i_dut (.I_CORE_CLK(clk), .I_RST(rst), .I_CE(1'b1), .I_LS_OSC(ls),
    .I_OPT_BYTE(opt), .I_REG_WR(wr), .I_REG_RD(rd), .I_REG_BITOP(bop),
    .I_REG_ADDR(addr), .I_REG_WDATA(wd), .O_REG_RDATA(rdata),
    .I_FETCH(fch), .I_DATA_ACC(dac), .I_ACC_ADDR(aad), .I_AREA_HIT(hit),
    .I_HALT(halt), .I_STOP(stp), .I_LS_OSC_STOP(ostp), .O_RST_REQ(req),
    .O_CAUSE_FLAG(flag), .O_RUNNING(run));
  wwd_host_model i_host (.clk(clk), .rst_req(req), .ls_osc(ls),
    .req_n(req_n));
  task automatic chk(string s, logic [31:0] e, logic [31:0] g);
    check_count++;
    if (g !== e) begin
      err_count++;
      $display("CHECK FAILED %s expected %0h seen %0h", s, e, g);
    end
  endtask
  task automatic boot(wwd_byte_t o);
    // callers never pair select 000 with window 00
    opt <= o;
    rst <= 1'b1;
    hit <= 1'b1;
    halt <= 1'b0;
    stp <= 1'b0;
    ostp <= 1'b0;
    repeat (5) @(posedge clk);
    rst <= 1'b0;
    // three load edges, first access on the fourth
    repeat (4) @(posedge clk);
    base = req_n;
  endtask
  task automatic acc(logic w, logic b, wwd_addr_t a, wwd_byte_t d);
    @(posedge clk);
    wr <= w;
    rd <= !w;
    bop <= b;
    addr <= a;
    wd <= d;
    @(posedge clk);
    wr <= 1'b0;
    rd <= 1'b0;
    bop <= 1'b0;
    #1;
  endtask
  task automatic key(wwd_byte_t d, logic b);
    acc(1'b1, b, `WWD_KEY_ADDR, d);
  endtask
  task automatic mem(logic f, wwd_addr_t a);
    @(posedge clk);
    fch <= f;
    dac <= !f;
    aad <= a;
    @(posedge clk);
    fch <= 1'b0;
    dac <= 1'b0;
    repeat (4) @(posedge clk);
  endtask
  task automatic t_read();
    boot(8'h30);
    acc(1'b0, 1'b0, `WWD_KEY_ADDR, 8'h00);
    chk("key rd", `WWD_KEY_RST_ON, rdata);
    chk("run", 1, run);
    key(`WWD_KEY_VALUE, 1'b0);
    acc(1'b0, 1'b0, `WWD_KEY_ADDR, 8'h00);
    chk("rd after key", `WWD_KEY_RST_ON, rdata);
    acc(1'b0, 1'b0, 16'hff98, 8'h00);
    chk("other rd", 8'h00, rdata);
    boot(8'h20);
    hit <= 1'b0;
    acc(1'b0, 1'b0, `WWD_KEY_ADDR, 8'h00);
    chk("rd off", `WWD_KEY_RST_OFF, rdata);
    chk("run off", 0, run);
    key(8'h55, 1'b0);
    mem(1'b1, 16'h1000);
    chk("off quiet", 0, req_n - base);
    $display("read test done");
  endtask
  task automatic t_fault();
    for (int k = 0; k < 3; k++) begin
      boot(8'h30);
      if (k == 2)
        key(`WWD_KEY_VALUE, 1'b0);
      key(k == 0 ? 8'h55 : `WWD_KEY_VALUE, k == 1);
      chk("flag", 1, flag);
      repeat (8) @(posedge clk);
      chk("pulses", 1, req_n - base);
    end
    $display("fault test done");
  endtask
  task automatic t_open();
    boot(8'h30);
    key(`WWD_KEY_VALUE, 1'b0);
    repeat (2) begin
      repeat (600 * 8) @(posedge clk);
      key(`WWD_KEY_VALUE, 1'b0);
    end
    repeat (600 * 8) @(posedge clk);
    chk("open key", 0, req_n - base);
    repeat (450 * 8) @(posedge clk);
    chk("ovf", 1, req_n - base);
    $display("window test done");
  endtask
  task automatic t_ovf();
    boot(8'h72);
    key(`WWD_KEY_VALUE, 1'b0);
    key(`WWD_KEY_VALUE, 1'b0);
    repeat (2040 * 8) @(posedge clk);
    chk("early", 0, req_n - base);
    repeat (16 * 8) @(posedge clk);
    chk("ovf n1", 1, req_n - base);
    $display("overflow test done");
  endtask
  task automatic t_acc();
    boot(8'h30);
    mem(1'b0, 16'h1000);
    hit <= 1'b0;
    mem(1'b0, `WWD_EXEMPT0_LO);
    mem(1'b0, `WWD_EXEMPT0_HI);
    mem(1'b0, `WWD_EXEMPT1_LO);
    chk("exempt", 0, req_n - base);
    mem(1'b0, 16'hffd0);
    chk("gap", 1, req_n - base);
    boot(8'h30);
    hit <= 1'b0;
    mem(1'b1, `WWD_EXEMPT1_HI);
    chk("fetch", 1, req_n - base);
    $display("access test done");
  endtask
  task automatic t_pause();
    boot(8'h30);
    key(`WWD_KEY_VALUE, 1'b0);
    ostp <= 1'b1;
    repeat (1100 * 8) @(posedge clk);
    #1;
    chk("stop run", 0, run);
    chk("stop ovf", 0, req_n - base);
    key(8'h55, 1'b0);
    repeat (8) @(posedge clk);
    chk("held req", 0, req_n - base);
    ostp <= 1'b0;
    repeat (8) @(posedge clk);
    chk("late req", 1, req_n - base);
    boot(8'h30);
    key(`WWD_KEY_VALUE, 1'b0);
    repeat (300 * 8) @(posedge clk);
    halt <= 1'b1;
    repeat (1100 * 8) @(posedge clk);
    halt <= 1'b0;
    // a cleared count would still be short of overflow here
    repeat (600 * 8) @(posedge clk);
    chk("resume", 0, req_n - base);
    repeat (200 * 8) @(posedge clk);
    chk("resume ovf", 1, req_n - base);
    boot(8'h31);
    key(`WWD_KEY_VALUE, 1'b0);
    stp <= 1'b1;
    repeat (1100 * 8) @(posedge clk);
    chk("lock ovf", 1, req_n - base);
    stp <= 1'b0;
    $display("pause test done");
  endtask
  task automatic summarize();
    $display("checks %0d mismatches %0d", check_count, err_count);
    if (err_count == 0 && check_count > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  always @(posedge clk) begin
    cyc++;
    if (cyc == 90000) begin
      err_count++;
      summarize();
    end
  end
  initial begin
    t_read();
    t_fault();
    t_open();
    t_ovf();
    t_acc();
    t_pause();
    summarize();
  end
endmodule
`default_nettype wire
